// ### include/ftc_consts.svh
// offsets, field positions, reset values and timing counts of the timer
`ifndef FTC_CONSTS_SVH
`define FTC_CONSTS_SVH

// register indices; byte address is four times the index
`define FTC_IDX_CAP_HI 8'h14
`define FTC_IDX_CAP_LO 8'h15
`define FTC_IDX_CMP_HI 8'h16
`define FTC_IDX_CMP_LO 8'h17
`define FTC_IDX_CNT_HI 8'h18
`define FTC_IDX_CNT_LO 8'h19
`define FTC_IDX_ALT_HI 8'h1A
`define FTC_IDX_ALT_LO 8'h1B
`define FTC_IDX_CTRL 8'h12
`define FTC_IDX_FLAGS 8'h13

// timer_control bits
`define FTC_CTL_LATCH_IE 7
`define FTC_CTL_MATCH_IE 6
`define FTC_CTL_WRAP_IE 5
`define FTC_CTL_RUN 4
`define FTC_CTL_EDGE 1
`define FTC_CTL_LEVEL 0
`define FTC_CTL_MASK 8'hF3

// timer_flags bits
`define FTC_FLG_LATCH 7
`define FTC_FLG_MATCH 6
`define FTC_FLG_WRAP 5

// reset values and timing
`define FTC_CNT_PRESET 16'hFFFC
`define FTC_CNT_MAX 16'hFFFF
`define FTC_CTRL_RESET 8'h00
`define FTC_PRESCALE_LAST 2'h3

`endif

// ### include/ftc_pkg.sv
// types shared by the free-running timer
package ftc_pkg;

    typedef struct packed {
        logic [7:0] idx;
        logic write;
        logic valid;
    } ftc_bus_req_t;

    typedef struct packed {
        logic latch_ie;
        logic match_ie;
        logic wrap_ie;
        logic run;
        logic edge_rise;
        logic level;
    } ftc_ctrl_t;

    typedef struct packed {
        logic latch;
        logic match;
        logic wrap;
    } ftc_flags_t;

endpackage

// ### verilog/ftc_timer.sv
// free-running 16-bit timer with one capture and one compare channel
`timescale 1ns/1ps
`include "ftc_consts.svh"

// --------------------------------------------------------------
// Notes on behaviour
// --------------------------------------------------------------
// Notes on behaviour
// - counter ticks once per four clocks
// - counter reads never disturb counting
// - primary and mirror pairs return same count
// - lone low read returns live low byte
// - high read freezes low byte until low read
// - mirror reads never clear wrap flag
// - reset presets FFFC; counts once run set
// - wrap FFFF to 0000 sets wrap flag
// - compare register free, never reset
// - equality sets match flag, loads pin level
// - match raises request when enabled
// - compare high write suspends until low write
// - byte write leaves other byte alone
// - chosen edge captures counter, no reset
// - capture loads count at chosen edge
// - each chosen edge while run set overwrites capture unless blocked, sets flag
// - capture high read blocks until low read
// - capture from bit seven, compare on six
// - six control bits, three interrupt enables
// - run clear holds timer in reset state
// - edge select and pin level polarity
// - flags clear: status then low-byte access
module ftc_timer (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic port_b_bit_seven,
    input wire logic match_pin_enable,
    output logic port_b_bit_six_o,
    output logic port_b_bit_six_oe,
    output logic timer_irq
);
    import ftc_pkg::*;

    // ----------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------
    ftc_bus_req_t req;
    ftc_bus_req_t wr_pend_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
    logic rd;
    logic wr;

    always_comb begin
        req.idx = haddr[9:2];
        req.write = hwrite;
        req.valid = hsel && hready && htrans[1] && haddr[31:10] == 22'h0
            && haddr[1:0] == 2'h0;
    end

    assign rd = req.valid && !req.write;
    assign wr = wr_pend_r.valid;

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
        hit = (idx == want);
    endfunction

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    ftc_ctrl_t ctrl_r;
    ftc_flags_t flags_r;
    ftc_flags_t armed_r;
    logic [15:0] count_r;
    logic [1:0] presc_r;
    logic [7:0] cnt_buf_r;
    logic cnt_frozen_r;
    logic [15:0] cmp_r;
    logic cmp_hold_r;
    logic [15:0] cap_r;
    logic cap_hold_r;
    logic [2:0] pin_sync_r;
    logic tick;
    logic tick_d_r;
    logic wrap_ev;
    logic match_ev;
    logic cap_ev;
    logic match_out_r;
    logic pin_oe_r;
    logic irq_r;
    logic clr_latch;
    logic clr_match;
    logic clr_wrap;

    assign tick = ctrl_r.run && presc_r == `FTC_PRESCALE_LAST;
    assign wrap_ev = tick && count_r == `FTC_CNT_MAX;
    assign match_ev = tick_d_r && !cmp_hold_r && count_r == cmp_r;
    assign cap_ev = ctrl_r.run && !cap_hold_r
        && pin_sync_r[2] != pin_sync_r[1]
        && pin_sync_r[1] == ctrl_r.edge_rise;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_pend_r <= '0;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            wr_pend_r.idx <= req.idx;
            wr_pend_r.write <= req.write;
            wr_pend_r.valid <= req.valid && req.write;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    // read data captured in the address phase, stands through the data phase
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hrdata_r <= 32'h0;
        end else if (rd) begin
            if (hit(req.idx, `FTC_IDX_CAP_HI)) begin
                hrdata_r <= {24'h0, cap_r[15:8]};
            end else if (hit(req.idx, `FTC_IDX_CAP_LO)) begin
                hrdata_r <= {24'h0, cap_r[7:0]};
            end else if (hit(req.idx, `FTC_IDX_CMP_HI)) begin
                hrdata_r <= {24'h0, cmp_r[15:8]};
            end else if (hit(req.idx, `FTC_IDX_CMP_LO)) begin
                hrdata_r <= {24'h0, cmp_r[7:0]};
            end else if (hit(req.idx, `FTC_IDX_CNT_HI) || hit(req.idx, `FTC_IDX_ALT_HI)) begin
                hrdata_r <= {24'h0, count_r[15:8]};
            end else if (hit(req.idx, `FTC_IDX_CNT_LO) || hit(req.idx, `FTC_IDX_ALT_LO)) begin
                hrdata_r <= {24'h0, cnt_frozen_r ? cnt_buf_r : count_r[7:0]};
            end else if (hit(req.idx, `FTC_IDX_CTRL)) begin
                hrdata_r <= {24'h0, ctrl_r.latch_ie, ctrl_r.match_ie, ctrl_r.wrap_ie,
                    ctrl_r.run, 2'h0, ctrl_r.edge_rise, ctrl_r.level};
            end else if (hit(req.idx, `FTC_IDX_FLAGS)) begin
                hrdata_r <= {24'h0, flags_r, 5'h0};
            end else begin
                hrdata_r <= 32'h0;
            end
        end
    end

    // ----------------------------------------------------------
    // control register
    // ----------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_r <= '0;
        end else if (wr && hit(wr_pend_r.idx, `FTC_IDX_CTRL)) begin
            ctrl_r.latch_ie <= hwdata[`FTC_CTL_LATCH_IE];
            ctrl_r.match_ie <= hwdata[`FTC_CTL_MATCH_IE];
            ctrl_r.wrap_ie <= hwdata[`FTC_CTL_WRAP_IE];
            ctrl_r.run <= hwdata[`FTC_CTL_RUN];
            ctrl_r.edge_rise <= hwdata[`FTC_CTL_EDGE];
            ctrl_r.level <= hwdata[`FTC_CTL_LEVEL];
        end
    end

    // ----------------------------------------------------------
    // prescaler and counter
    // ----------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n || !ctrl_r.run) begin
            presc_r <= 2'h0;
            count_r <= `FTC_CNT_PRESET;
            tick_d_r <= 1'b0;
        end else begin
            presc_r <= presc_r + 2'h1;
            tick_d_r <= tick;
            if (tick) begin
                count_r <= count_r + 16'h1;
            end
        end
    end

    // low byte buffer shared by both counter pairs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_frozen_r <= 1'b0;
            cnt_buf_r <= 8'h0;
        end else if (rd && (hit(req.idx, `FTC_IDX_CNT_HI) || hit(req.idx, `FTC_IDX_ALT_HI))) begin
            if (!cnt_frozen_r) begin
                cnt_buf_r <= count_r[7:0];
            end
            cnt_frozen_r <= 1'b1;
        end else if (rd && (hit(req.idx, `FTC_IDX_CNT_LO) || hit(req.idx, `FTC_IDX_ALT_LO))) begin
            cnt_frozen_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // compare channel
    // ----------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (wr && hit(wr_pend_r.idx, `FTC_IDX_CMP_HI)) begin
            cmp_r[15:8] <= hwdata[7:0];
        end
        if (wr && hit(wr_pend_r.idx, `FTC_IDX_CMP_LO)) begin
            cmp_r[7:0] <= hwdata[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cmp_hold_r <= 1'b0;
        end else if (wr && hit(wr_pend_r.idx, `FTC_IDX_CMP_HI)) begin
            cmp_hold_r <= 1'b1;
        end else if (wr && hit(wr_pend_r.idx, `FTC_IDX_CMP_LO)) begin
            cmp_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            match_out_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else begin
            if (match_ev) begin
                match_out_r <= ctrl_r.level;
            end
            pin_oe_r <= match_pin_enable;
        end
    end

    // ----------------------------------------------------------
    // capture channel
    // ----------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_sync_r <= 3'h0;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], port_b_bit_seven};
        end
    end

    // no reset: contents survive reset
    always_ff @(posedge mclk) begin
        if (cap_ev) begin
            cap_r <= count_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cap_hold_r <= 1'b0;
        end else if (rd && hit(req.idx, `FTC_IDX_CAP_HI)) begin
            cap_hold_r <= 1'b1;
        end else if (rd && hit(req.idx, `FTC_IDX_CAP_LO)) begin
            cap_hold_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // flags, two-step clear, request
    // ----------------------------------------------------------
    assign clr_latch = armed_r.latch && rd && hit(req.idx, `FTC_IDX_CAP_LO);
    assign clr_match = armed_r.match && (rd || wr)
        && hit(rd ? req.idx : wr_pend_r.idx, `FTC_IDX_CMP_LO);
    assign clr_wrap = armed_r.wrap && rd && hit(req.idx, `FTC_IDX_CNT_LO);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            armed_r <= '0;
        end else if (rd && hit(req.idx, `FTC_IDX_FLAGS)) begin
            armed_r <= flags_r;
        end else begin
            armed_r.latch <= armed_r.latch && !clr_latch;
            armed_r.match <= armed_r.match && !clr_match;
            armed_r.wrap <= armed_r.wrap && !clr_wrap;
        end
    end

    // set wins over clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flags_r <= '0;
        end else begin
            flags_r.latch <= cap_ev || (flags_r.latch && !clr_latch);
            flags_r.match <= match_ev || (flags_r.match && !clr_match);
            flags_r.wrap <= wrap_ev || (flags_r.wrap && !clr_wrap);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (flags_r.latch && ctrl_r.latch_ie) || (flags_r.match && ctrl_r.match_ie)
                || (flags_r.wrap && ctrl_r.wrap_ie);
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign port_b_bit_six_o = match_out_r;
    assign port_b_bit_six_oe = pin_oe_r;
    assign timer_irq = irq_r;

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    tick_period_a: assert property (@(posedge mclk) disable iff (!rst_n)
        tick |=> !tick [*3]) else $error("counter ticked faster than every four clocks");
    count_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ctrl_r.run && $past(ctrl_r.run) && !$past(tick) |-> $stable(count_r))
        else $error("counter moved without a tick");
    run_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !ctrl_r.run |=> count_r == `FTC_CNT_PRESET) else $error("stopped counter not preset");
    wrap_sets_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wrap_ev |=> flags_r.wrap && count_r == 16'h0) else $error("wrap did not set flag");
    mirror_keeps_a: assert property (@(posedge mclk) disable iff (!rst_n)
        flags_r.wrap && rd && (req.idx == `FTC_IDX_ALT_HI || req.idx == `FTC_IDX_ALT_LO)
        |=> flags_r.wrap) else $error("mirror read cleared wrap flag");
    match_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
        match_ev |=> match_out_r == $past(ctrl_r.level) && flags_r.match)
        else $error("match did not load pin level");
    cmp_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        cmp_hold_r |=> $stable(match_out_r)) else $error("compare ran while suspended");
    cap_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
        cap_ev |=> cap_r == $past(count_r) && flags_r.latch)
        else $error("capture did not load counter");
    cap_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
        cap_hold_r |=> $stable(cap_r)) else $error("capture changed while blocked");
    irq_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        flags_r.match && ctrl_r.match_ie |=> timer_irq) else $error("request missing");
endmodule

// ### sim/ftc_host_model.sv
// bus master standing in for the host processor
`timescale 1ns/1ps
module ftc_host_model (
    input wire logic mclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // one single word transfer; caller enters just after a rising edge
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                        output logic [7:0] rd);
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata[7:0];
        // released data lines do not keep the last value
        hwdata <= ~{24'h0, wd};
    endtask
endmodule

// ### sim/free_running_timer_capture_compare_bench.sv
// self-checking bench for the free-running timer
`timescale 1ns/1ps
`include "ftc_consts.svh"
module free_running_timer_capture_compare_bench;
    logic mclk, rst_n, pin, mpe, po, poe, irq, hreadyout, hresp, hwrite;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    localparam logic [15:0] PRE = `FTC_CNT_PRESET;
    localparam logic [7:0] RUN = 8'h01 << `FTC_CTL_RUN;
    localparam logic [7:0] LVL = 8'h01 << `FTC_CTL_LEVEL;
    localparam logic [7:0] EDG = 8'h01 << `FTC_CTL_EDGE;
    localparam logic [7:0] WIE = 8'h01 << `FTC_CTL_WRAP_IE;
    localparam logic [7:0] MIE = 8'h01 << `FTC_CTL_MATCH_IE;
    localparam logic [7:0] LIE = 8'h01 << `FTC_CTL_LATCH_IE;
    localparam logic [7:0] WF = 8'h01 << `FTC_FLG_WRAP;
    localparam logic [7:0] MF = 8'h01 << `FTC_FLG_MATCH;
    localparam logic [7:0] LF = 8'h01 << `FTC_FLG_LATCH;
    localparam logic [7:0] CTL = `FTC_IDX_CTRL;
    localparam logic [7:0] FLG = `FTC_IDX_FLAGS;
    localparam logic [7:0] CH = `FTC_IDX_CNT_HI;
    localparam logic [7:0] CL = `FTC_IDX_CNT_LO;
    localparam logic [7:0] AH = `FTC_IDX_ALT_HI;
    localparam logic [7:0] AL = `FTC_IDX_ALT_LO;
    localparam logic [7:0] KH = `FTC_IDX_CMP_HI;
    localparam logic [7:0] KL = `FTC_IDX_CMP_LO;
    localparam logic [7:0] PH = `FTC_IDX_CAP_HI;
    localparam logic [7:0] PL = `FTC_IDX_CAP_LO;

    ftc_timer DUT (
        .mclk(mclk),
        .rst_n(rst_n),
        .hsel(1'b1),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .port_b_bit_seven(pin),
        .match_pin_enable(mpe),
        .port_b_bit_six_o(po),
        .port_b_bit_six_oe(poe),
        .timer_irq(irq)
    );

    ftc_host_model host (
        .mclk(mclk),
        .hready(hreadyout),
        .hrdata(hrdata),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] v);
        host.xfer(idx, 1'b0, 8'h00, v);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] v;
        host.xfer(idx, 1'b1, d, v);
    endtask

    task automatic rc(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        rd(idx, v);
        chk(what, exp, v);
    endtask

    task automatic wait_pin(input logic lvl, input int lim);
        int k;
        k = 0;
        while (po !== lvl && k < lim) begin
            @(posedge mclk);
            k++;
        end
        chk("compare pin", {7'h0, lvl}, {7'h0, po});
    endtask

    // one rising then falling capture pin edge; c is the count just before
    task automatic cap_edge(output logic [7:0] c);
        rd(AL, c);
        pin <= 1'b1;
        idle(8);
        pin <= 1'b0;
        idle(8);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk("hreadyout", 8'h01, {7'h0, hreadyout});
        chk("hresp", 8'h00, {7'h0, hresp});
        rc("ctrl", CTL, `FTC_CTRL_RESET);
        rc("flags", FLG, 8'h00);
        rc("cnt hi", CH, PRE[15:8]);
        rc("cnt lo", CL, PRE[7:0]);
        idle(20);
        rc("alt hi", AH, PRE[15:8]);
        rc("alt lo", AL, PRE[7:0]);
        rc("unmapped", 8'h30, 8'h00);
        wr(KH, 8'h80);
        wr(KL, 8'h00);
        rc("cmp hi", KH, 8'h80);
        wr(CTL, 8'hFF);
        rc("ctrl mask", CTL, `FTC_CTL_MASK);
        wr(CTL, 8'h00);
        idle(1);
        rc("stopped", CL, PRE[7:0]);
        $display("test reset done");
    endtask

    task automatic t_count();
        logic [7:0] a, b;
        wr(CTL, RUN);
        rd(CL, a);
        idle(6);
        rd(CL, b);
        chk("tick rate", 8'h02, b - a);
        rd(CL, a);
        idle(2);
        rd(AL, b);
        chk("alt pair", 8'h01, b - a);
        rd(CH, a);
        idle(18);
        rd(CH, a);
        idle(18);
        rd(CL, a);
        idle(2);
        rd(CL, b);
        chk("frozen lo", 8'h0B, b - a);
        wr(CTL, 8'h00);
        wr(CTL, RUN | WIE);
        idle(24);
        chk("wrap irq", 8'h01, {7'h0, irq});
        rc("wrap flag", FLG, WF);
        rd(AH, a);
        rd(AL, a);
        rc("alt keeps", FLG, WF);
        rd(CL, a);
        rc("wrap clr", FLG, 8'h00);
        chk("irq low", 8'h00, {7'h0, irq});
        $display("test count done");
    endtask

    task automatic t_match();
        logic [7:0] a;
        mpe <= 1'b1;
        wr(CTL, 8'h00);
        wr(KL, 8'h10);
        rc("hi kept", KH, 8'h80);
        wr(KH, 8'h00);
        wr(KL, 8'h10);
        rc("cmp lo", KL, 8'h10);
        wr(CTL, RUN | MIE | LVL);
        wait_pin(1'b1, 100);
        chk("pin oe", 8'h01, {7'h0, poe});
        idle(2);
        chk("match irq", 8'h01, {7'h0, irq});
        rc("match flag", FLG, MF | WF);
        wr(CTL, MIE);
        wr(KH, 8'h00);
        wr(CTL, RUN | MIE);
        idle(120);
        chk("suspended", 8'h01, {7'h0, po});
        wr(KL, 8'h40);
        wait_pin(1'b0, 400);
        rd(FLG, a);
        wr(KL, 8'h40);
        rc("match clr", FLG, WF);
        mpe <= 1'b0;
        idle(2);
        chk("oe off", 8'h00, {7'h0, poe});
        $display("test match done");
    endtask

    task automatic t_capture();
        logic [7:0] a, c, v;
        wr(CTL, RUN | LIE | EDG);
        cap_edge(c);
        rc("latch flag", FLG, LF | WF);
        chk("latch irq", 8'h01, {7'h0, irq});
        cap_edge(c);
        rd(PH, a);
        rd(PL, v);
        chk("capture", 8'h01, {7'h0, (v - c - 8'h01) <= 8'h01});
        rc("latch clr", FLG, WF);
        rd(PH, a);
        cap_edge(c);
        rc("blocked", PL, v);
        cap_edge(c);
        rd(PL, v);
        chk("lone lo", 8'h01, {7'h0, (v - c - 8'h01) <= 8'h01});
        $display("test capture done");
    endtask

    initial begin
        rst_n = 1'b0;
        pin = 1'b0;
        mpe = 1'b0;
        idle(2);
        rst_n <= 1'b1;
        idle(1);
        t_reset();
        t_count();
        t_match();
        t_capture();
        final_report();
    end
endmodule
